// ===== rtl/ckos_pkg.sv
// Shared constants and types for the clock output select block
package ckos_pkg;

    // ****************************************
    // Three-level mode pin encoding
    // ****************************************
    localparam logic [1:0] MODE_LOW = 2'h0; // Pin below low threshold
    localparam logic [1:0] MODE_HIGH = 2'h1; // Pin above high threshold
    localparam logic [1:0] MODE_MID = 2'h2; // Pin at mid level

    // ****************************************
    // Frequency select and CPU rate codes
    // ****************************************
    localparam logic [1:0] FSEL_HIZ = 2'h0; // Mid mode: all outputs float
    localparam logic [1:0] FSEL_TEST = 2'h1; // Mid mode: test clock mode
    localparam logic [1:0] CPU_66 = 2'h0; // CPU at 66 MHz
    localparam logic [1:0] CPU_100 = 2'h1; // CPU at 100 MHz
    localparam logic [1:0] CPU_200 = 2'h2; // CPU at 200 MHz
    localparam logic [1:0] CPU_133 = 2'h3; // CPU at 133 MHz

    // ****************************************
    // Clock sources and divider codes
    // ****************************************
    localparam logic [1:0] SRC_VCO = 2'h0; // Internal VCOs
    localparam logic [1:0] SRC_EXT66 = 2'h1; // External 66 MHz input
    localparam logic [1:0] SRC_TEST = 2'h2; // Test clock on crystal input
    localparam logic [3:0] DIV_NONE = 4'h0; // Synthesised, no divider
    localparam logic [3:0] DIV_1 = 4'h1; // Source passed straight
    localparam logic [3:0] DIV_2 = 4'h2; // Source divided by two
    localparam logic [3:0] DIV_4 = 4'h4; // Source divided by four
    localparam logic [3:0] DIV_8 = 4'h8; // Source divided by eight

    // ****************************************
    // Serial port protocol values
    // ****************************************
    localparam logic [7:0] ADDR_BYTE_WRITE = 8'hd2; // Own address, write
    localparam logic [7:0] CMD_CODE = 8'h00; // Only legal command code
    localparam logic [7:0] COUNT_MIN = 8'h01; // Least byte count
    localparam logic [7:0] COUNT_MAX = 8'h20; // Largest byte count
    localparam logic [3:0] BITS_PER_BYTE = 4'h8; // Bits before acknowledge
    localparam logic [2:0] IDX_ADDR = 3'h0; // Address byte slot
    localparam logic [2:0] IDX_CMD = 3'h1; // Command byte slot
    localparam logic [2:0] IDX_COUNT = 3'h2; // Byte count slot
    localparam logic [2:0] IDX_DATA0 = 3'h3; // Control byte slot
    localparam logic [2:0] IDX_LAST = 3'h7; // Slot counter saturates here

    // ****************************************
    // Control byte layout and reset values
    // ****************************************
    localparam int CTL_SPREAD_BIT = 7; // Spread spectrum enable
    localparam int CTL_SPARE_BIT = 6; // Reads zero
    localparam int CTL_VCH_BIT = 5; // Shared output selects 48 MHz
    localparam int CTL_CPUSTOP_BIT = 4; // Live CPU stop pin level
    localparam int CTL_PCISTOP_BIT = 3; // Software PCI stop
    localparam int CTL_MODE_BIT = 2; // Mode pin seen high at power-up
    localparam int CTL_FHI_BIT = 1; // Upper frequency select strap
    localparam int CTL_FLO_BIT = 0; // Lower frequency select strap
    localparam logic SPREAD_RST = 1'b0; // Spread off after power-up
    localparam logic VCH_RST = 1'b0; // Shared output at 66 MHz
    localparam logic PCISTOP_RST = 1'b0; // PCI clocks running
    localparam logic SPARE_VALUE = 1'b0; // Unused bit value

    // ****************************************
    // Bus receiver states
    // ****************************************
    typedef enum logic [1:0] {
        BUS_IDLE, // No transfer for us
        BUS_RECV, // Shifting a byte in
        BUS_ACK, // Holding the data line low
        BUS_SKIP // Not ours or refused, wait for stop
    } ckos_bus_state_t;

    // Pins from outside the clock domain
    typedef struct packed {
        logic scl; // Serial clock
        logic sda; // Serial data line level
        logic [1:0] modeSelectPin; // Three-level mode select
        logic freqSelectHi; // Upper frequency select
        logic freqSelectLo; // Lower frequency select
        logic powerDownN; // Power down, active low
        logic cpuClockStopN; // CPU clock stop, active low
        logic pciClockStopN; // PCI clock stop, active low
        logic powerGoodStrobeN; // Strap sample strobe, active low
        logic currentMultiplierSelect; // CPU output current range
    } ckos_pins_t;

    // Clock plan handed to the PLL and output drivers
    typedef struct packed {
        logic allHiZ; // Every clock output floats
        logic [1:0] source; // Where the clocks come from
        logic [1:0] cpuFreq; // CPU rate code
        logic [3:0] cpuDiv; // CPU divider from source
        logic [3:0] sixtySixDiv; // Sixty-six outputs divider
        logic [3:0] pciDiv; // PCI outputs divider
        logic [3:0] refDiv; // Reference output divider
        logic [3:0] usbDotDiv; // 48 MHz outputs divider
        logic cpuRun; // CPU pairs toggling
        logic cpuParkIref2; // True CPU outputs parked at twice ref
        logic cpuCompFloat; // CPU complements floating
        logic sixtySixRun; // Sixty-six outputs toggling
        logic bufferedRun; // Buffered sixty-six outputs toggling
        logic pciFreeRun; // Free-running PCI outputs toggling
        logic pciRun; // Seven stoppable PCI outputs toggling
        logic usbDotRun; // 48 MHz outputs toggling
        logic refRun; // Reference output toggling
        logic vcoOscOn; // VCOs and oscillator powered
        logic spreadOn; // Down-spread modulation on
        logic videoHub48; // Shared output at 48 MHz
        logic sharedPinInput; // Shared pin acts as 66 MHz input
        logic currentMult; // Captured current multiplier select
    } ckos_plan_t;

endpackage

// ===== rtl/ckos_sync.sv
// Two flip-flop synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ps
module ckos_sync #(
    parameter int WIDTH = 11
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [WIDTH-1:0] meta; // First stage, read by second only
        logic [WIDTH-1:0] stable; // Second stage, safe to use
    } ckos_sync_state_t;

    ckos_sync_state_t state_q;
    ckos_sync_state_t state_d;

    // Refuse a bundle with no bits
    initial begin
        if (WIDTH < 1) begin
            $error("ckos_sync needs at least one bit");
        end
    end

    // ****************************************
    // Per-bit stages
    // ****************************************
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        // Each pin shifts through its own pair of stages
        always_comb begin
            state_d.meta[i] = async[i];
            state_d.stable[i] = state_q.meta[i];
        end
    end

    // Register both stages
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= '1; // Idle level: no false edge or strap
        end else begin
            state_q <= state_d;
        end
    end

    assign synced = state_q.stable;

endmodule

// ===== rtl/ckos_clock_control.sv
// Clock output selection, gating and serial control byte of the synthesizer
//
// How it works
// - Mode high: shared pin is 66 input
// - Mid with select 01 divides test clock
// - Power down parks CPU, holds rest low
// - CPU stop parks true CPU, complements float
// - PCI stop halts the seven PCI clocks
// - Serial port takes block writes, byte zero first
// - Answer only address byte D2, write
// - Transfer valid once count byte acknowledged
// - Registers take defaults at power-up
// - Bit 7 enables down spread, default off
// - Bit 5 picks 48 MHz shared output
// - Bit 4 reads live CPU stop pin
// - Bit 3 software stops seven PCI clocks
// - Bits 2..0 hold power-up select straps
// - Straps sampled while power good low, once
`timescale 1ns/1ps
module ckos_clock_control
    import ckos_pkg::*;
#(
    parameter int PIN_WIDTH = 11
) (
    input wire logic clk,
    input wire logic reset,
    input wire ckos_pins_t pinsRaw,
    output logic sdaOut,
    output logic sdaOe,
    output ckos_plan_t clockPlan,
    output logic [7:0] controlStatusByte
);

    // Refuse a pin bundle that does not match the pin record
    initial begin
        if (PIN_WIDTH != $bits(ckos_pins_t)) begin
            $error("ckos_clock_control pin width mismatch");
        end
    end

    // ****************************************
    // State record
    // ****************************************
    typedef struct packed {
        ckos_bus_state_t busState; // Serial receiver state
        logic sclPrev; // Serial clock one sample ago
        logic sdaPrev; // Serial data one sample ago
        logic [3:0] bitCnt; // Bits taken in the current byte
        logic [7:0] shift; // Incoming byte, MSB first
        logic [2:0] byteIdx; // Byte slot within the transfer
        logic [5:0] remain; // Data bytes still allowed
        logic sdaOe; // Pulling the data line low
        logic spread; // Spread spectrum enable
        logic vch48; // Shared output at 48 MHz
        logic pciSwStop; // Software PCI stop
        logic strapDone; // Straps have been captured
        logic [1:0] strapMode; // Captured mode pin
        logic strapHi; // Captured upper frequency select
        logic strapLo; // Captured lower frequency select
        logic strapMult; // Captured current multiplier
        ckos_plan_t plan; // Registered clock plan
        logic [7:0] ctl; // Registered control byte image
    } ckos_state_t;

    ckos_state_t state_q; // Current state
    ckos_state_t state_d; // Next state
    ckos_pins_t pins; // Pins after synchronising

    // ****************************************
    // Pin synchroniser
    // ****************************************
    ckos_sync #(
        .WIDTH(PIN_WIDTH)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .async(pinsRaw),
        .synced(pins)
    );

    // ****************************************
    // Next-state logic
    // ****************************************
    logic sclRise; // Serial clock rising edge seen
    logic sclFall; // Serial clock falling edge seen
    logic startSeen; // Data falls while clock high
    logic stopSeen; // Data rises while clock high
    logic [1:0] effMode; // Mode in force
    logic [1:0] effFsel; // Frequency selects in force
    logic byteAck; // Acknowledge the byte just taken

    // Edge and bus condition detection
    always_comb begin
        sclRise = pins.scl && !state_q.sclPrev;
        sclFall = !pins.scl && state_q.sclPrev;
        startSeen = pins.scl && state_q.sclPrev && state_q.sdaPrev
            && !pins.sda;
        stopSeen = pins.scl && state_q.sclPrev && !state_q.sdaPrev
            && pins.sda;
    end

    // Decide the answer to a completed byte
    always_comb begin
        byteAck = 1'b0;
        unique case (state_q.byteIdx)
            // Only our own write address
            IDX_ADDR: byteAck = (state_q.shift == ADDR_BYTE_WRITE);
            // Command must be zero
            IDX_CMD: byteAck = (state_q.shift == CMD_CODE);
            // Count must lie in range
            IDX_COUNT: byteAck = (state_q.shift >= COUNT_MIN)
                && (state_q.shift <= COUNT_MAX);
            // Data within the announced count
            default: byteAck = (state_q.remain != 6'h00);
        endcase
    end

    // Straps in force: captured copy once taken, live pins before
    always_comb begin
        if (state_q.strapDone) begin
            effMode = state_q.strapMode;
            effFsel = {state_q.strapHi, state_q.strapLo};
        end else begin
            effMode = pins.modeSelectPin;
            effFsel = {pins.freqSelectHi, pins.freqSelectLo};
        end
    end

    // Main next-state process
    always_comb begin
        state_d = state_q;
        state_d.sclPrev = pins.scl;
        state_d.sdaPrev = pins.sda;

        // Strap capture on the first low power good sample
        if (!state_q.strapDone && !pins.powerGoodStrobeN) begin
            state_d.strapDone = 1'b1;
            state_d.strapMode = pins.modeSelectPin;
            state_d.strapHi = pins.freqSelectHi;
            state_d.strapLo = pins.freqSelectLo;
            state_d.strapMult = pins.currentMultiplierSelect;
        end

        // Serial receiver, start and stop win over everything
        if (startSeen) begin
            state_d.busState = BUS_RECV;
            state_d.bitCnt = 4'h0;
            state_d.byteIdx = IDX_ADDR;
            state_d.sdaOe = 1'b0;
        end else if (stopSeen) begin
            state_d.busState = BUS_IDLE;
            state_d.sdaOe = 1'b0;
        end else begin
            unique case (state_q.busState)
                // Waiting for a start
                BUS_IDLE: state_d.sdaOe = 1'b0;
                // Released until the stop
                BUS_SKIP: state_d.sdaOe = 1'b0;
                // Shift bits in on rising clock, MSB first
                BUS_RECV: begin
                    if (sclRise && state_q.bitCnt < BITS_PER_BYTE) begin
                        state_d.shift = {state_q.shift[6:0], pins.sda};
                        state_d.bitCnt = state_q.bitCnt + 4'h1;
                    end else if (sclFall && state_q.bitCnt == BITS_PER_BYTE)
                    begin
                        state_d.bitCnt = 4'h0;
                        if (byteAck) begin
                            state_d.busState = BUS_ACK;
                            state_d.sdaOe = 1'b1;
                        end else begin
                            state_d.busState = BUS_SKIP;
                        end
                        // Count byte arms the data bytes
                        if (byteAck && state_q.byteIdx == IDX_COUNT) begin
                            state_d.remain = state_q.shift[5:0];
                        end
                        // Data bytes use up the count
                        if (byteAck && state_q.byteIdx >= IDX_DATA0) begin
                            state_d.remain = state_q.remain - 6'h01;
                        end
                        // Byte zero writes the control bits
                        if (byteAck && state_q.byteIdx == IDX_DATA0) begin
                            state_d.spread =
                                state_q.shift[CTL_SPREAD_BIT];
                            state_d.vch48 =
                                state_q.shift[CTL_VCH_BIT];
                            state_d.pciSwStop =
                                state_q.shift[CTL_PCISTOP_BIT];
                        end
                    end
                end
                // Release after the acknowledge clock
                BUS_ACK: begin
                    if (sclFall) begin
                        state_d.sdaOe = 1'b0;
                        state_d.busState = BUS_RECV;
                        if (state_q.byteIdx != IDX_LAST) begin
                            state_d.byteIdx = state_q.byteIdx + 3'h1;
                        end
                    end
                end
            endcase
        end

        // Clock plan defaults
        state_d.plan = '0;
        state_d.plan.cpuFreq = effFsel;
        state_d.plan.currentMult = state_q.strapMult;
        state_d.plan.spreadOn = state_q.spread;
        state_d.plan.videoHub48 = state_q.vch48;

        // Source and dividers from the mode
        if (effMode == MODE_MID) begin
            if (effFsel == FSEL_TEST) begin
                state_d.plan.source = SRC_TEST;
                state_d.plan.cpuDiv = DIV_2;
                state_d.plan.sixtySixDiv = DIV_4;
                state_d.plan.pciDiv = DIV_8;
                state_d.plan.refDiv = DIV_1;
                state_d.plan.usbDotDiv = DIV_2;
            end else begin
                // Float mode, reserved codes float as well
                state_d.plan.allHiZ = 1'b1;
            end
        end else if (effMode == MODE_HIGH) begin
            state_d.plan.source = SRC_EXT66;
            state_d.plan.sharedPinInput = 1'b1;
            state_d.plan.sixtySixDiv = DIV_1;
            state_d.plan.pciDiv = DIV_2;
        end else begin
            state_d.plan.source = SRC_VCO;
        end

        // Output group gating
        if (state_d.plan.allHiZ) begin
            state_d.plan.vcoOscOn = 1'b0;
        end else if (!pins.powerDownN) begin
            // Everything low, CPU parked, oscillators off
            state_d.plan.cpuParkIref2 = 1'b1;
            state_d.plan.cpuCompFloat = 1'b1;
        end else begin
            state_d.plan.vcoOscOn = 1'b1;
            state_d.plan.sixtySixRun = 1'b1;
            state_d.plan.bufferedRun = 1'b1;
            state_d.plan.pciFreeRun = 1'b1;
            state_d.plan.usbDotRun = 1'b1;
            state_d.plan.refRun = 1'b1;
            state_d.plan.cpuRun = pins.cpuClockStopN;
            state_d.plan.cpuParkIref2 = !pins.cpuClockStopN;
            state_d.plan.cpuCompFloat = !pins.cpuClockStopN;
            state_d.plan.pciRun = pins.pciClockStopN
                && !state_q.pciSwStop;
        end

        // Control byte image
        state_d.ctl[CTL_SPREAD_BIT] = state_q.spread;
        state_d.ctl[CTL_SPARE_BIT] = SPARE_VALUE;
        state_d.ctl[CTL_VCH_BIT] = state_q.vch48;
        state_d.ctl[CTL_CPUSTOP_BIT] = pins.cpuClockStopN;
        state_d.ctl[CTL_PCISTOP_BIT] = state_q.pciSwStop;
        state_d.ctl[CTL_MODE_BIT] = (state_q.strapMode == MODE_HIGH);
        state_d.ctl[CTL_FHI_BIT] = state_q.strapHi;
        state_d.ctl[CTL_FLO_BIT] = state_q.strapLo;
    end

    // ****************************************
    // State register
    // ****************************************
    // Power-up defaults so the part runs without the serial port
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= '0;
            state_q.busState <= BUS_IDLE;
            state_q.sclPrev <= 1'b1;
            state_q.sdaPrev <= 1'b1;
            state_q.spread <= SPREAD_RST;
            state_q.vch48 <= VCH_RST;
            state_q.pciSwStop <= PCISTOP_RST;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Every output but the constant comes from a flip-flop
    assign sdaOut = 1'b0; // Open drain, only ever pulls low
    assign sdaOe = state_q.sdaOe;
    assign clockPlan = state_q.plan;
    assign controlStatusByte = state_q.ctl;

endmodule

// ===== tb/ckos_clock_control_properties.sv
// Port checks for the clock control block
`timescale 1ns/1ps
module ckos_clock_control_properties
    import ckos_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire ckos_pins_t pinsRaw,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire ckos_plan_t clockPlan,
    input wire logic [7:0] controlStatusByte
);
    logic [2:0] rstAge; // Edges since reset release
    logic pgSeen; // Strobe went low, straps may freeze
    ckos_pins_t p1, p2, p3; // Pins delayed to match the plan
    logic aged; // Pin pipeline refilled
    logic ok; // Plan still follows live pins
    logic norm; // Mode low or high
    logic run; // Normal mode, powered
    logic [1:0] fs; // Select pins as a code
    // Pin pipeline and age counters
    always_ff @(posedge clk) begin
        p1 <= pinsRaw;
        p2 <= p1;
        p3 <= p2;
        rstAge <= reset ? 3'h0 : rstAge + {2'h0, rstAge != 3'h7};
        pgSeen <= !reset && (pgSeen || !pinsRaw.powerGoodStrobeN);
    end
    assign aged = rstAge >= 3'h4;
    assign ok = aged && !pgSeen;
    assign fs = {p3.freqSelectHi, p3.freqSelectLo};
    assign norm = ok && p3.modeSelectPin != MODE_MID;
    assign run = norm && p3.powerDownN;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_cpu_rate_map:
        assert property (norm |-> clockPlan.cpuFreq == fs)
        else $error("cpu rate code wrong");
    a_ext66_mode:
        assert property (ok && p3.modeSelectPin == MODE_HIGH |->
            clockPlan.source == SRC_EXT66 && clockPlan.sharedPinInput &&
            clockPlan.pciDiv == DIV_2 && clockPlan.sixtySixDiv == DIV_1)
        else $error("external 66 plan wrong");
    a_vco_mode:
        assert property (ok && p3.modeSelectPin == MODE_LOW |->
            clockPlan.source == SRC_VCO && !clockPlan.sharedPinInput)
        else $error("internal vco plan wrong");
    a_float_all:
        assert property (ok && p3.modeSelectPin == MODE_MID &&
            fs != FSEL_TEST |-> clockPlan.allHiZ && !clockPlan.vcoOscOn)
        else $error("outputs not floating");
    a_test_divide:
        assert property (ok && p3.modeSelectPin == MODE_MID &&
            fs == FSEL_TEST |-> clockPlan.source == SRC_TEST &&
            clockPlan.cpuDiv == DIV_2 && clockPlan.sixtySixDiv == DIV_4 &&
            clockPlan.pciDiv == DIV_8 && clockPlan.refDiv == DIV_1 &&
            clockPlan.usbDotDiv == DIV_2)
        else $error("test clock dividers wrong");
    a_power_down:
        assert property (norm && !p3.powerDownN |-> clockPlan.cpuParkIref2
            && clockPlan.cpuCompFloat && !(clockPlan.sixtySixRun ||
            clockPlan.pciFreeRun || clockPlan.pciRun ||
            clockPlan.usbDotRun || clockPlan.refRun || clockPlan.vcoOscOn))
        else $error("power down gating wrong");
    a_cpu_park:
        assert property (run && !p3.cpuClockStopN |-> clockPlan.cpuParkIref2
            && clockPlan.cpuCompFloat && !clockPlan.cpuRun &&
            clockPlan.sixtySixRun && clockPlan.pciFreeRun)
        else $error("cpu stop gating wrong");
    a_pci_halt:
        assert property (run && !p3.pciClockStopN |-> !clockPlan.pciRun &&
            clockPlan.pciFreeRun && clockPlan.cpuRun == p3.cpuClockStopN)
        else $error("pci stop gating wrong");
    a_stop_bit_live:
        assert property (aged |->
            controlStatusByte[CTL_CPUSTOP_BIT] == p3.cpuClockStopN)
        else $error("cpu stop status bit stale");
    a_ack_stands:
        assert property ($rose(sdaOe) |-> sdaOe [*6])
        else $error("acknowledge too short");
endmodule

// ===== tb/ckos_smbus_host.sv
// Bus controller model issuing block writes
`timescale 1ns/1ps
module ckos_smbus_host (
    input wire logic clk,
    input wire logic sdaLine,
    output logic scl,
    output logic sda
);
    // Lines idle released, pulled high
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Start: data falls while clock high
    task automatic start_cond();
        @(posedge clk) sda <= 1'b0;
        tick(3);
        @(posedge clk) scl <= 1'b0;
    endtask
    // Eight bits msb first, ninth clock with data released
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic [8:0] bits;
        bits = {b, 1'b1};
        for (int i = 8; i >= 0; i--) begin
            @(posedge clk) sda <= bits[i];
            tick(2);
            @(posedge clk) scl <= 1'b1;
            tick(3);
            ack = ~sdaLine;
            @(posedge clk) scl <= 1'b0;
        end
    endtask
    // Stop: data rises while clock high
    task automatic stop_cond();
        @(posedge clk) sda <= 1'b0;
        tick(2);
        @(posedge clk) scl <= 1'b1;
        tick(3);
        @(posedge clk) sda <= 1'b1;
        tick(4);
    endtask
endmodule

// ===== tb/ckos_clock_control_tb_top.sv
// Self-checking bench for the clock control block
`timescale 1ns/1ps
module ckos_clock_control_tb_top
    import ckos_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    ckos_pins_t pinsTb, pinsDut; // Bench pins, pins with bus merged
    logic sdaOut, sdaOe, hostScl, hostSda, sdaLine, ackSeen;
    ckos_plan_t plan;
    logic [7:0] ctl;
    int errorCnt = 0;
    int checkCount = 0;
    int cycleCnt = 0;
    always #10 clk = ~clk;
    // Open-drain data wire with pull-up
    assign sdaLine = hostSda & (sdaOe ? sdaOut : 1'b1);
    always_comb begin
        pinsDut = pinsTb;
        pinsDut.scl = hostScl;
        pinsDut.sda = sdaLine;
    end
    ckos_clock_control #(.PIN_WIDTH(11)) u_dut (.clk(clk), .reset(reset),
        .pinsRaw(pinsDut), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .clockPlan(plan), .controlStatusByte(ctl));
    ckos_smbus_host u_host (.clk(clk), .sdaLine(sdaLine), .scl(hostScl),
        .sda(hostSda));
    task automatic check_val(input string what, input logic [7:0] exp,
                             input logic [7:0] got);
        checkCount++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        if (errorCnt == 0 && checkCount > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Pins: mode, selects, {power, cpu stop, pci stop, strobe}
    task automatic set_pins(input logic [1:0] m, input logic [1:0] f,
                            input logic [3:0] c);
        @(posedge clk);
        pinsTb.modeSelectPin <= m;
        {pinsTb.freqSelectHi, pinsTb.freqSelectLo} <= f;
        {pinsTb.powerDownN, pinsTb.cpuClockStopN, pinsTb.pciClockStopN,
            pinsTb.powerGoodStrobeN} <= c;
        repeat (5) @(posedge clk);
    endtask
    // One transfer; the first nAck bytes must be acknowledged
    task automatic bus_write(input logic [7:0] seq[$], input int nAck);
        u_host.start_cond();
        foreach (seq[i]) begin
            u_host.send_byte(seq[i], ackSeen);
            check_val("ack", 8'(i < nAck), {7'h00, ackSeen});
            if (!ackSeen) break;
        end
        u_host.stop_cond();
        repeat (4) @(posedge clk);
    endtask
    // Hang guard
    always @(posedge clk) begin
        cycleCnt <= cycleCnt + 1;
        if (cycleCnt == 6000) begin
            errorCnt++;
            finish_test();
        end
    end
    initial begin
        static logic [1:0] modes[3] = '{MODE_LOW, MODE_HIGH, MODE_MID};
        logic [1:0] src;
        pinsTb = '0;
        {pinsTb.powerDownN, pinsTb.cpuClockStopN, pinsTb.pciClockStopN,
            pinsTb.powerGoodStrobeN} = 4'hf;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        check_val("defaults", 8'h10, ctl);
        // Every mode and select code
        foreach (modes[k]) begin
            for (int f = 0; f < 4; f++) begin
                set_pins(modes[k], 2'(f), 4'hf);
                src = modes[k] == MODE_HIGH ? SRC_EXT66 :
                    (modes[k] == MODE_MID ? SRC_TEST : SRC_VCO);
                if (modes[k] == MODE_MID && f != 1)
                    check_val("hiz", 8'h01, {7'h00, plan.allHiZ});
                else
                    check_val("plan", {4'h0, src, 2'(f)},
                        {1'b0, plan.allHiZ, 2'h0, plan.source, plan.cpuFreq});
            end
        end
        // Power down and stop pin combinations
        for (int g = 0; g < 8; g++) begin
            set_pins(MODE_LOW, 2'h0, {3'(g), 1'b1});
            check_val("gate", {4'h0, g[2] ? {g[1], g[0], 2'h3} : 4'h0},
                {4'h0, plan.cpuRun, plan.pciRun, plan.pciFreeRun,
                plan.vcoOscOn});
            check_val("stopbit", {7'h00, g[1]}, {7'h00, ctl[4]});
        end
        bus_write('{8'hd2, 8'h00, 8'h01, 8'ha8}, 4);
        check_val("ctl", 8'ha8, ctl & 8'he8);
        check_val("plan", 8'h0d, {4'h0, plan.spreadOn, plan.videoHub48,
            plan.pciRun, plan.pciFreeRun});
        bus_write('{8'hd4, 8'h00, 8'h01, 8'h00}, 0);
        bus_write('{8'hd3, 8'h00}, 0);
        bus_write('{8'hd2, 8'h01, 8'h01, 8'h00}, 1);
        bus_write('{8'hd2, 8'h00, 8'h00, 8'h00}, 2);
        bus_write('{8'hd2, 8'h00, 8'h21, 8'h00}, 2);
        check_val("ctl", 8'ha8, ctl & 8'he8);
        bus_write('{8'hd2, 8'h00, 8'h02, 8'h00, 8'hff, 8'hff}, 5);
        check_val("ctl", 8'h00, ctl & 8'he8);
        // Straps taken at the first strobe only
        set_pins(MODE_HIGH, 2'h2, 4'he);
        set_pins(MODE_LOW, 2'h1, 4'hf);
        set_pins(MODE_LOW, 2'h1, 4'he);
        check_val("straps", 8'h06, {5'h00, ctl[2:0]});
        finish_test();
    end
endmodule
bind ckos_clock_control ckos_clock_control_properties u_props (
    .clk(clk), .reset(reset), .pinsRaw(pinsRaw), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .clockPlan(clockPlan),
    .controlStatusByte(controlStatusByte));
